/* File: design/ipf_defs.svh */
`ifndef IPF_DEFS_SVH
`define IPF_DEFS_SVH
`define IPF_PARTS_HI 31
`define IPF_PARTS_LO 30
`define IPF_SUM_HI 29
`define IPF_SUM_LO 28
`define IPF_HDR_BIT 27
`define IPF_SFMT_HI 26
`define IPF_SFMT_LO 23
`define IPF_DFMT_HI 26
`define IPF_DFMT_LO 21
`define IPF_SFMT_MAX 4'h3
`define IPF_DFMT_MAX 6'h1A
`define IPF_CODE_RSVD 2'h3
`define IPF_FLAG_ABS 6
`define IPF_FLAG_TF_HI 3
`define IPF_FLAG_TF_LO 2
`define IPF_HDR_WORDS 3'h6
`define IPF_CH_ID_W 16
`endif

/* File: design/ipf_pkg.sv */
package ipf_pkg;
  typedef enum logic {IPF_STILL, IPF_DYNAMIC} ipf_fmt_t;
  typedef enum logic [1:0] {IPF_MID, IPF_FIRST, IPF_LAST, IPF_BOTH} ipf_parts_t;
  typedef enum logic [1:0] {IPF_PARTIAL, IPF_ONE, IPF_MANY, IPF_PIECES} ipf_sum_t;
endpackage

/* File: design/ipf_word_if.sv */
interface ipf_word_if;
  logic [15:0] word;
  logic valid;
  logic ready;
  modport src (output word, output valid, input ready);
  modport dst (input word, input valid, output ready);
endinterface

/* File: design/ipf_byte_packer.sv */
module ipf_byte_packer
  import ipf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_byte_last,
  output logic o_byte_ready,
  ipf_word_if.src wout
);
  logic [7:0] low_ff;
  logic [7:0] nxt_low;
  logic half_ff;
  logic nxt_half;
  logic [15:0] word_ff;
  logic [15:0] nxt_word;
  logic valid_ff;
  logic nxt_valid;
  assign o_byte_ready = ~valid_ff | wout.ready;
  assign wout.word = word_ff;
  assign wout.valid = valid_ff;
  always_comb
  begin
    nxt_low = low_ff;
    nxt_half = half_ff;
    nxt_word = word_ff;
    nxt_valid = valid_ff & ~wout.ready;
    if (i_clear)
    begin
      nxt_half = 1'b0;
      nxt_valid = 1'b0;
    end
    else if (i_byte_valid && o_byte_ready)
    begin
      // earlier byte low, filler high on odd end
      if (half_ff)
      begin
        nxt_word = {i_byte, low_ff};
        nxt_valid = 1'b1;
        nxt_half = 1'b0;
      end
      else if (i_byte_last)
      begin
        nxt_word = {8'h00, i_byte};
        nxt_valid = 1'b1;
      end
      else
      begin
        nxt_low = i_byte;
        nxt_half = 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      low_ff <= 8'h00;
      half_ff <= 1'b0;
      word_ff <= 16'h0000;
      valid_ff <= 1'b0;
    end
    else
    begin
      low_ff <= nxt_low;
      half_ff <= nxt_half;
      word_ff <= nxt_word;
      valid_ff <= nxt_valid;
    end
  end
endmodule

/* File: design/ipf_formatter.sv */
`include "ipf_defs.svh"
module ipf_formatter
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_pkt_start,
  input wire ipf_pkg::ipf_fmt_t i_fmt,
  input wire ipf_pkg::ipf_parts_t i_parts,
  input wire ipf_pkg::ipf_sum_t i_sum,
  input wire logic i_hdr_en,
  input wire logic [5:0] i_pix_fmt,
  input wire logic [`IPF_CH_ID_W-1:0] i_chan_id,
  input wire logic i_setup_done,
  input wire logic [7:0] i_pkt_flags,
  input wire logic [47:0] i_rel_time,
  input wire logic [63:0] i_abs_time,
  input wire logic i_seg_start,
  input wire logic i_seg_first,
  input wire logic [31:0] i_seg_len,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_byte_last,
  output logic o_byte_ready,
  output logic o_busy,
  output logic o_setup_req,
  output logic o_cfg_err,
  output logic [15:0] o_word,
  output logic o_word_valid,
  input wire logic i_word_ready
);
  import ipf_pkg::*;
  typedef enum {S_IDLE, S_CW, S_WAIT, S_HDR, S_DATA} ipf_state_t;
  ipf_word_if pk_if();
  ipf_state_t st_ff;
  ipf_state_t nxt_st;
  logic [31:0] cw_ff;
  logic [31:0] nxt_cw;
  logic [95:0] hdr_ff;
  logic [95:0] nxt_hdr;
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  logic [15:0] word_ff;
  logic [15:0] nxt_word;
  logic wv_ff;
  logic nxt_wv;
  logic hdr_en_ff;
  logic nxt_hdr_en;
  logic dyn_ff;
  logic nxt_dyn;
  logic [`IPF_CH_ID_W-1:0] id_ff;
  logic [`IPF_CH_ID_W-1:0] nxt_id;
  logic [5:0] pix_ff;
  logic [5:0] nxt_pix;
  logic setup_ff;
  logic nxt_setup;
  logic err_ff;
  logic nxt_err;
  logic last_seen_ff;
  logic nxt_last_seen;
  logic pk_clear;
  logic pk_ready;
  logic out_free;
  logic in_data;
  logic byte_go;

  // codes legal for the chosen format
  function automatic logic code_ok(input logic dyn, input logic [1:0] p, input logic [1:0] s,
                                   input logic [5:0] f);
    if (dyn)
      code_ok = (p != `IPF_CODE_RSVD) && (s != `IPF_CODE_RSVD) && (f <= `IPF_DFMT_MAX);
    else
      code_ok = (f[3:0] <= `IPF_SFMT_MAX) && (f[5:4] == 2'h0);
  endfunction

  // channel word with reserved bits zero
  function automatic logic [31:0] chan_word(input logic dyn, input logic [1:0] p,
                                            input logic [1:0] s, input logic h,
                                            input logic [5:0] f);
    chan_word = 32'h0000_0000;
    chan_word[`IPF_PARTS_HI:`IPF_PARTS_LO] = p;
    chan_word[`IPF_SUM_HI:`IPF_SUM_LO] = s;
    chan_word[`IPF_HDR_BIT] = h;
    if (dyn)
      chan_word[`IPF_DFMT_HI:`IPF_DFMT_LO] = f;
    else
      chan_word[`IPF_SFMT_HI:`IPF_SFMT_LO] = f[3:0];
  endfunction

  assign out_free = ~wv_ff | i_word_ready;
  assign in_data = (st_ff == S_DATA);
  assign byte_go = in_data & i_byte_valid & ~last_seen_ff;
  assign pk_clear = (st_ff == S_IDLE);
  assign pk_if.ready = in_data & out_free;

  ipf_byte_packer u_pack
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clear(pk_clear),
    .i_byte_valid(byte_go),
    .i_byte(i_byte),
    .i_byte_last(i_byte_last),
    .o_byte_ready(pk_ready),
    .wout(pk_if.src)
  );
  assign o_byte_ready = pk_ready & in_data & ~last_seen_ff;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cw = cw_ff;
    nxt_hdr = hdr_ff;
    nxt_idx = idx_ff;
    nxt_word = word_ff;
    nxt_wv = wv_ff & ~i_word_ready;
    nxt_hdr_en = hdr_en_ff;
    nxt_dyn = dyn_ff;
    nxt_id = id_ff;
    nxt_pix = pix_ff;
    nxt_setup = setup_ff & ~i_setup_done;
    nxt_err = err_ff;
    nxt_last_seen = last_seen_ff;
    case (st_ff)
      S_IDLE:
      begin
        if (i_pkt_start)
        begin
          nxt_dyn = (i_fmt == IPF_DYNAMIC);
          nxt_err = ~code_ok(nxt_dyn, i_parts, i_sum, i_pix_fmt);
          // new id or new format on a dynamic channel needs a setup record
          if (nxt_dyn && ((i_chan_id != id_ff) || (i_pix_fmt != pix_ff)))
          begin
            nxt_setup = 1'b1;
            nxt_id = i_chan_id;
            nxt_pix = i_pix_fmt;
          end
          if (!nxt_err)
          begin
            nxt_hdr_en = i_hdr_en;
            nxt_cw = chan_word(nxt_dyn, i_parts, i_sum, i_hdr_en, i_pix_fmt);
            nxt_idx = 3'h0;
            nxt_st = S_CW;
          end
        end
      end
      S_CW:
      begin
        // packet data held back until setup record is out
        if (out_free && !setup_ff)
        begin
          nxt_word = idx_ff[0] ? cw_ff[31:16] : cw_ff[15:0];
          nxt_wv = 1'b1;
          nxt_idx = idx_ff + 3'h1;
          if (idx_ff[0])
            nxt_st = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (i_seg_start)
        begin
          nxt_last_seen = 1'b0;
          nxt_idx = 3'h0;
          // capture time at the segment start pulse
          nxt_hdr[95:64] = i_seg_len;
          if (i_pkt_flags[`IPF_FLAG_ABS])
            nxt_hdr[63:0] = i_abs_time;
          else
            nxt_hdr[63:0] = {16'h0000, i_rel_time};
          if (hdr_en_ff && (!dyn_ff || i_seg_first))
            nxt_st = S_HDR;
          else
            nxt_st = S_DATA;
        end
        else if (i_pkt_start)
          nxt_st = S_IDLE;
      end
      S_HDR:
      begin
        if (out_free)
        begin
          nxt_word = hdr_ff[idx_ff*16 +: 16];
          nxt_wv = 1'b1;
          nxt_idx = idx_ff + 3'h1;
          if (idx_ff == `IPF_HDR_WORDS - 3'h1)
            nxt_st = S_DATA;
        end
      end
      S_DATA:
      begin
        if (byte_go && o_byte_ready && i_byte_last)
          nxt_last_seen = 1'b1;
        if (pk_if.valid && out_free)
        begin
          nxt_word = pk_if.word;
          nxt_wv = 1'b1;
          if (last_seen_ff)
            nxt_st = S_WAIT;
        end
      end
      default:
        nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      st_ff <= S_IDLE;
      cw_ff <= 32'h0000_0000;
      hdr_ff <= 96'h0;
      idx_ff <= 3'h0;
      word_ff <= 16'h0000;
      wv_ff <= 1'b0;
      hdr_en_ff <= 1'b0;
      dyn_ff <= 1'b0;
      id_ff <= '1;
      pix_ff <= 6'h3F;
      setup_ff <= 1'b0;
      err_ff <= 1'b0;
      last_seen_ff <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cw_ff <= nxt_cw;
      hdr_ff <= nxt_hdr;
      idx_ff <= nxt_idx;
      word_ff <= nxt_word;
      wv_ff <= nxt_wv;
      hdr_en_ff <= nxt_hdr_en;
      dyn_ff <= nxt_dyn;
      id_ff <= nxt_id;
      pix_ff <= nxt_pix;
      setup_ff <= nxt_setup;
      err_ff <= nxt_err;
      last_seen_ff <= nxt_last_seen;
      o_busy <= (nxt_st != S_IDLE);
    end
  end

  assign o_word = word_ff;
  assign o_word_valid = wv_ff;
  assign o_setup_req = setup_ff;
  assign o_cfg_err = err_ff;
endmodule

/* File: verification/ipf_sink.sv */
module ipf_sink
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_slow,
  input wire logic [15:0] i_word,
  input wire logic i_valid,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_ff;
  logic [15:0] q[$];
  // stalls two cycles of three when slow
  assign o_ready = !i_slow || cnt_ff == 2'h2;
  always @(posedge i_clk_sys)
  begin
    cnt_ff <= (!i_rst_n || cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
    if (i_rst_n && i_valid && o_ready)
      q.push_back(i_word);
  end
endmodule

/* File: verification/ipf_formatter_props.sv */
module ipf_formatter_props
  import ipf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_pkt_start,
  input wire ipf_pkg::ipf_fmt_t i_fmt,
  input wire ipf_pkg::ipf_parts_t i_parts,
  input wire ipf_pkg::ipf_sum_t i_sum,
  input wire logic [5:0] i_pix_fmt,
  input wire logic i_setup_done,
  input wire logic i_word_ready,
  input wire logic o_busy,
  input wire logic o_setup_req,
  input wire logic o_cfg_err,
  input wire logic [15:0] o_word,
  input wire logic o_word_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic go;
  logic bad;
  assign go = i_pkt_start && !o_busy;
  assign bad = i_fmt == IPF_DYNAMIC ?
    (i_parts == IPF_BOTH || i_sum == IPF_PIECES || i_pix_fmt > 6'h1A) : i_pix_fmt > 6'h03;
  reset_clear_a: assert property ($rose(i_rst_n) |-> !o_word_valid && !o_busy)
    else $error("outputs not clear after reset");
  still_first_a: assert property (go && !bad && i_fmt == IPF_STILL && !o_setup_req
    |-> ##2 o_word_valid && o_word == 16'h0000) else $error("still low half wrong");
  code_refuse_a: assert property (go && bad |=> o_cfg_err && !o_busy)
    else $error("reserved code not refused");
  code_accept_a: assert property (go && !bad |=> !o_cfg_err && o_busy)
    else $error("legal code refused");
  word_hold_a: assert property (o_word_valid && !i_word_ready && !i_pkt_start
    |=> o_word_valid && $stable(o_word)) else $error("word dropped before ready");
  setup_hold_a: assert property (o_setup_req |-> !o_word_valid)
    else $error("word sent before setup record");
  setup_clear_a: assert property (o_setup_req && i_setup_done |=> !o_setup_req)
    else $error("setup request stuck");
  err_keep_a: assert property (!i_pkt_start |=> $stable(o_cfg_err))
    else $error("error flag changed without start");
  cover property (go && !bad && i_fmt == IPF_STILL);
  cover property (go && bad);
  cover property ($rose(o_setup_req));
endmodule

bind ipf_formatter ipf_formatter_props props (.i_clk_sys, .i_rst_n, .i_pkt_start, .i_fmt,
  .i_parts, .i_sum, .i_pix_fmt, .i_setup_done, .i_word_ready, .o_busy, .o_setup_req,
  .o_cfg_err, .o_word, .o_word_valid);

/* File: verification/test_image_packet_body_formatter.sv */
module test_image_packet_body_formatter
  import ipf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_pkt_start = 1'b0, i_hdr_en = 1'b0;
  ipf_fmt_t i_fmt = IPF_STILL;
  ipf_parts_t i_parts = IPF_MID;
  ipf_sum_t i_sum = IPF_PARTIAL;
  logic [5:0] i_pix_fmt = 6'h00;
  logic [15:0] i_chan_id = 16'h0005;
  logic [7:0] i_pkt_flags = 8'h00, i_byte = 8'h00;
  logic [47:0] i_rel_time = 48'h123456789ABC;
  logic [63:0] i_abs_time = 64'h0123456789ABCDEF;
  logic [31:0] i_seg_len = 32'h0;
  logic i_setup_done = 1'b0, i_seg_start = 1'b0, i_seg_first = 1'b1, slow = 1'b0;
  logic i_byte_valid = 1'b0, i_byte_last = 1'b0, i_word_ready;
  logic o_byte_ready, o_busy, o_setup_req, o_cfg_err, o_word_valid;
  logic [15:0] o_word;
  int num_errors = 0, n_checks = 0, n;
  ipf_formatter dut (.i_clk_sys, .i_rst_n, .i_pkt_start, .i_fmt, .i_parts, .i_sum, .i_hdr_en,
    .i_pix_fmt, .i_chan_id, .i_setup_done, .i_pkt_flags, .i_rel_time, .i_abs_time,
    .i_seg_start, .i_seg_first, .i_seg_len, .i_byte_valid, .i_byte, .i_byte_last,
    .o_byte_ready, .o_busy, .o_setup_req, .o_cfg_err, .o_word, .o_word_valid, .i_word_ready);
  ipf_sink sink (.i_clk_sys, .i_rst_n, .i_slow(slow), .i_word(o_word), .i_valid(o_word_valid),
    .o_ready(i_word_ready));
  initial
    forever #50 i_clk_sys = ~i_clk_sys;
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stuck(int i, int lim);
    if (i >= lim)
    begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic open_pkt(ipf_fmt_t f, ipf_parts_t p, ipf_sum_t s, logic h, logic [5:0] x);
    @(posedge i_clk_sys);
    i_fmt <= f;
    i_parts <= p;
    i_sum <= s;
    i_hdr_en <= h;
    i_pix_fmt <= x;
    i_pkt_start <= 1'b1;
    @(posedge i_clk_sys);
    i_pkt_start <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  task automatic wait_words(int cnt);
    int i;
    for (i = 0; i < 400 && sink.q.size() < cnt; i++)
      @(posedge i_clk_sys);
    stuck(i, 400);
  endtask
  // one segment of len bytes, byte k = b0 + 11h * k
  task automatic segment(logic [31:0] len, logic [7:0] b0);
    int i;
    @(posedge i_clk_sys);
    i_seg_start <= 1'b1;
    i_seg_len <= len;
    @(posedge i_clk_sys);
    i_seg_start <= 1'b0;
    for (int k = 0; k < len; k++)
    begin
      i_byte_valid <= 1'b1;
      i_byte <= b0 + 8'(8'h11 * k);
      i_byte_last <= (k == len - 1);
      for (i = 0; i < 200; i++)
      begin
        @(negedge i_clk_sys);
        if (o_byte_ready === 1'b1)
          break;
      end
      stuck(i, 200);
      @(posedge i_clk_sys);
    end
    i_byte_valid <= 1'b0;
  endtask
  task automatic match(string nm, logic [15:0] e[$]);
    wait_words(e.size());
    foreach (e[j])
      chk(nm, e[j], sink.q[j]);
    sink.q.delete();
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    open_pkt(IPF_STILL, IPF_BOTH, IPF_PIECES, 1'b1, 6'h03);
    wait_words(2);
    segment(32'h3, 8'h11);
    match("still body", {16'h0000, 16'hF980, 16'h9ABC, 16'h5678, 16'h1234, 16'h0000,
      16'h0003, 16'h0000, 16'h2211, 16'h0033});
    open_pkt(IPF_STILL, IPF_MID, IPF_PARTIAL, 1'b0, 6'h00);
    slow <= 1'b1;
    i_pkt_flags <= 8'h40;
    open_pkt(IPF_DYNAMIC, IPF_FIRST, IPF_PARTIAL, 1'b1, 6'h1A);
    for (n = 0; n < 50 && o_setup_req !== 1'b1; n++)
      @(posedge i_clk_sys);
    chk("setup request", 16'h1, {15'h0, o_setup_req});
    chk("held words", 16'h0, 16'(sink.q.size()));
    i_setup_done <= 1'b1;
    @(posedge i_clk_sys);
    i_setup_done <= 1'b0;
    wait_words(2);
    segment(32'h2, 8'hAA);
    match("dynamic body", {16'h0000, 16'h4B40, 16'hCDEF, 16'h89AB, 16'h4567, 16'h0123,
      16'h0002, 16'h0000, 16'hBBAA});
    open_pkt(IPF_STILL, IPF_MID, IPF_PARTIAL, 1'b0, 6'h00);
    i_seg_first <= 1'b0;
    open_pkt(IPF_DYNAMIC, IPF_MID, IPF_PARTIAL, 1'b1, 6'h1A);
    wait_words(2);
    segment(32'h3, 8'h01);
    match("later segment", {16'h0000, 16'h0B40, 16'h1201, 16'h0023});
    open_pkt(IPF_STILL, IPF_MID, IPF_PARTIAL, 1'b0, 6'h00);
    for (n = 0; n < 4; n++)
    begin
      open_pkt(n < 3 ? IPF_DYNAMIC : IPF_STILL, n == 0 ? IPF_BOTH : IPF_MID,
        n == 1 ? IPF_PIECES : IPF_PARTIAL, 1'b0, n == 2 ? 6'h1B : 6'h04);
      chk("refused start", 16'h2, {14'h0, o_cfg_err, o_busy});
    end
    complete_run();
  end
endmodule
